// *** dram_refresh_access_sequencer_tb_top.sv ***
// bench of the dram refresh and access sequencer
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_access_sequencer_tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] strap = 3'h0;
  logic ext_n = 1'b1;
  logic addr_latch, chip_sel_n, bank_select, access_read_n, access_write_n;
  logic [7:0] row_addr, col_addr, mem_addr_out;
  logic ready, refresh_req_n_out, refresh_req_n_oe;
  logic row_strobe0_n, row_strobe1_n, col_strobe_n;
  wire logic wait_strap = strap[2];
  wire logic rate_select1 = strap[1];
  wire logic rate_select0 = strap[0];
  wire logic refresh_req_n_in = ext_n & ~(refresh_req_n_oe & ~refresh_req_n_out);
  wire logic refr = !row_strobe0_n & !row_strobe1_n;
  int err_count = 0;
  int checked = 0;
  always #20 core_clk = ~core_clk;
  drs_sequencer uut (.*);
  drs_cpu_model cpu (.*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic give_up;
    err_count++;
    report_and_stop;
  endtask
  task automatic wait_ref(output int n);
    logic p;
    {p, n} = {1'b1, 32'd0};
    for (int i = 1; i < 200 && n == 0; i++)
    begin
      @(posedge core_clk);
      if (refr && !p)
        n = i;
      p = refr;
    end
    if (n == 0)
      give_up;
  endtask
  task automatic t_access;
    int n[4];
    int w;
    logic [7:0] rs, cs;
    logic bs;
    for (int j = 0; j < 4; j++)
    begin
      @(posedge core_clk);
      strap <= j[1] ? 3'h4 : 3'h0;
      if (j[1])
        wait_ref(w);
      repeat (6) @(posedge core_clk);
      cpu.access(j[1], j[0], j[0], 8'h5A ^ 8'(j), 8'hA5 ^ 8'(j), n[j], rs,
        cs, bs);
      if (n[j] == 0)
        give_up;
      check(rs, 8'h5A ^ 8'(j));
      check(cs, 8'hA5 ^ 8'(j));
      check({7'h00, bs}, 8'(j[0]));
    end
    check(8'(n[2] - n[0]), 8'h01);
    check(8'(n[3] - n[1]), 8'h01);
    $display("t_access end");
  endtask
  task automatic t_collide;
    int n, w;
    logic [7:0] rs, cs;
    logic bs;
    @(posedge core_clk);
    strap <= 3'h0;
    ext_n <= 1'b0;
    fork
      cpu.access(1'b1, 1'b1, 1'b1, 8'h3C, 8'hC3, n, rs, cs, bs);
      wait_ref(w);
    join
    if (n == 0)
      give_up;
    ext_n <= 1'b1;
    check(8'(w > 0 && w < 8), 8'h01);
    check(rs, 8'h3C);
    check(cs, 8'hC3);
    $display("t_collide end");
  endtask
  task automatic t_rates;
    int per[8] = '{0, 31, 46, 61, 46, 61, 76, 91};
    int w;
    for (int k = 1; k < 8; k++)
    begin
      @(posedge core_clk);
      strap <= 3'(k);
      wait_ref(w);
      wait_ref(w);
      check(8'(w), 8'(per[k]));
    end
    $display("t_rates end");
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    check({row_strobe0_n, row_strobe1_n, col_strobe_n, ready,
      refresh_req_n_oe, 3'h0}, 8'hF0);
    check(mem_addr_out, 8'h00);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_access;
    t_collide;
    t_rates;
    report_and_stop;
  end
endmodule // dram_refresh_access_sequencer_tb_top
`default_nettype wire

// *** drs_cpu_model.sv ***
// processor bus model issuing access cycles
`timescale 1ns/1ps
`default_nettype none
module drs_cpu_model
(
  // bus toward the sequencer
  input wire logic core_clk,
  output logic addr_latch,
  output logic chip_sel_n,
  output logic bank_select,
  output logic access_read_n,
  output logic access_write_n,
  output logic [7:0] row_addr,
  output logic [7:0] col_addr,
  // answers
  input wire logic ready,
  input wire logic [7:0] mem_addr_out,
  input wire logic row_strobe0_n,
  input wire logic row_strobe1_n,
  input wire logic col_strobe_n
);
  initial {addr_latch, chip_sel_n, bank_select, access_read_n,
    access_write_n, row_addr, col_addr} = {5'h0B, 16'h0000};
  task automatic access(input logic rd, input logic early,
    input logic bank, input logic [7:0] ra, input logic [7:0] ca,
    output int n, output logic [7:0] rs, output logic [7:0] cs,
    output logic bs);
    logic got;
    got = 1'b0;
    n = 0;
    @(posedge core_clk);
    addr_latch <= 1'b1;
    chip_sel_n <= 1'b0;
    bank_select <= bank;
    row_addr <= ra;
    col_addr <= ca;
    @(posedge core_clk);
    addr_latch <= 1'b0;
    row_addr <= ~ra;
    col_addr <= ~ca;
    for (int i = 0; i < 60 && n == 0; i++)
    begin
      if (i == 0 && early || i == 2 && !early)
        {access_read_n, access_write_n} <= {!rd, rd};
      @(posedge core_clk);
      if ((row_strobe0_n ^ row_strobe1_n) && !got)
        {got, rs, bs} = {1'b1, mem_addr_out, !row_strobe1_n};
      if (!col_strobe_n)
        cs = mem_addr_out;
      if (!col_strobe_n && ready)
        n = i + 1;
    end
    {access_read_n, access_write_n, chip_sel_n} <= 3'h7;
    repeat (3) @(posedge core_clk);
  endtask
endmodule // drs_cpu_model
`default_nettype wire

// *** drs_pkg.sv ***
// package of constants for the dram refresh/access sequencer
// Overview of operation
// - cycles run only once the arbiter grants access or refresh
// - both row strobes are driven in refresh, the bank's one row strobe in access, column strobe for access cycles only
// - ready is held low while a memory cycle cannot yet complete
// - address mux picks row then column, or refresh row in refresh
// - each refresh clears the refresh rate divider
// - each refresh decrements the refresh row counter by one
// - refresh versus access is decided on the rising clock edge only
// - latch high with refresh pending: next rising edge starts refresh
// - row address held at least 30 ns after row strobe falls
// - after access control, ready rises on a later rising edge
// - wait strap high inserts one wait state in every access
// - strap code picks external request or a clock divider rate
// - refresh row counter is eight bits, 256 rows
// - refresh request open-collector, held low until refresh address out
package drs_pkg;
  localparam int ROW_W = 8;
  localparam int DIV_W = 7;
  localparam logic [ROW_W-1:0] ROW_RST = 8'hFF;
  localparam logic [DIV_W-1:0] DIV_31 = 7'h1F;
  localparam logic [DIV_W-1:0] DIV_46 = 7'h2E;
  localparam logic [DIV_W-1:0] DIV_61 = 7'h3D;
  localparam logic [DIV_W-1:0] DIV_76 = 7'h4C;
  localparam logic [DIV_W-1:0] DIV_91 = 7'h5B;
  localparam logic [DIV_W-1:0] REQ_LEAD = 7'h04;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ROW_HOLD_NS = 30;
  localparam int ROW_HOLD_CYC = (ROW_HOLD_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam logic [1:0] HOLD_CYC = 2'(ROW_HOLD_CYC);
  localparam logic [2:0] REF_LEN3 = 3'h3;
  localparam logic [2:0] REF_LEN4 = 3'h4;
  typedef enum logic [2:0] {
    DRS_IDLE = 3'b000,
    DRS_ROW = 3'b001,
    DRS_COL = 3'b010,
    DRS_WAIT = 3'b011,
    DRS_DONE = 3'b100,
    DRS_REF = 3'b101
  } drs_state_type;
endpackage

// *** drs_seq_assertions.sv ***
// checker of sequencer strobe, address and ready timing
`timescale 1ns/1ps
`default_nettype none
module drs_seq_chk
(
  // watched ports
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wait_strap,
  input wire logic rate_select1,
  input wire logic rate_select0,
  input wire logic ready,
  input wire logic refresh_req_n_oe,
  input wire logic [drs_pkg::ROW_W-1:0] mem_addr_out,
  input wire logic row_strobe0_n,
  input wire logic row_strobe1_n,
  input wire logic col_strobe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic ras_any;
  logic refr;
  logic short_ref;
  logic [drs_pkg::ROW_W-1:0] last_ff;
  assign short_ref = $onehot({wait_strap, rate_select1, rate_select0});
  assign ras_any = !row_strobe0_n | !row_strobe1_n;
  assign refr = !row_strobe0_n & !row_strobe1_n;
  // row address of the previous refresh
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      last_ff <= 8'h00;
    else if ($rose(refr))
      last_ff <= mem_addr_out;
  cas_after_ras_a: assert property ($fell(col_strobe_n) |-> $past(ras_any))
    else $error("col strobe without row strobe");
  row_hold_a: assert property ($rose(ras_any) |=> $stable(mem_addr_out))
    else $error("row address not held");
  ready_nowait_a: assert property
    ($fell(col_strobe_n) && !wait_strap |=> ready) else $error("ready late");
  ready_wait_a: assert property
    ($fell(col_strobe_n) && wait_strap |=> !ready ##1 ready)
    else $error("wait state missing");
  ref_no_cas_a: assert property (refr |-> col_strobe_n)
    else $error("col strobe in refresh");
  ref_row_a: assert property ($rose(refr) |-> mem_addr_out == last_ff - 8'h01)
    else $error("refresh row not decremented");
  ref_len_a: assert property ($rose(refr) |-> ##[1:3] !refr)
    else $error("refresh too long");
  oe_ref_a: assert property ($rose(refresh_req_n_oe) |-> ##[0:4] refr)
    else $error("refresh did not follow request");
  ref_short_a: assert property
    ($rose(refr) && short_ref |=> !refr)
    else $error("short refresh length wrong");
  ref_long_a: assert property
    ($rose(refr) && !short_ref |=> refr ##1 !refr)
    else $error("long refresh length wrong");
  ref_not_ready_a: assert property (refr |-> !ready)
    else $error("ready high during refresh");
  cover property ($fell(col_strobe_n) && wait_strap);
  cover property ($rose(refr));
  cover property ($rose(refresh_req_n_oe));
endmodule // drs_seq_chk
bind drs_sequencer drs_seq_chk u_chk (.*);
`default_nettype wire

// *** drs_sequencer.sv ***
// dram refresh and access timing sequencer
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // processor side
  input wire logic addr_latch,
  input wire logic chip_sel_n,
  input wire logic bank_select,
  input wire logic access_read_n,
  input wire logic access_write_n,
  input wire logic [drs_pkg::ROW_W-1:0] row_addr,
  input wire logic [drs_pkg::ROW_W-1:0] col_addr,
  output logic ready,
  // straps
  input wire logic wait_strap,
  input wire logic rate_select1,
  input wire logic rate_select0,
  // refresh request pin
  input wire logic refresh_req_n_in,
  output logic refresh_req_n_out,
  output logic refresh_req_n_oe,
  // memory side
  output logic [drs_pkg::ROW_W-1:0] mem_addr_out,
  output logic row_strobe0_n,
  output logic row_strobe1_n,
  output logic col_strobe_n
);
  typedef struct packed {
    logic [2:0] strap;
    logic cs_n;
    logic bank;
    logic [drs_pkg::ROW_W-1:0] col;
    logic [drs_pkg::ROW_W-1:0] row;
    logic access_ctrl_n;
    logic ale;
  } drs_pins_type;
  typedef struct packed {
    drs_pins_type s1;
    drs_pins_type s2;
    logic [1:0] rq_sy;
    logic own;
    logic ale_d;
    logic req_d;
    logic acc_pend;
    logic bank;
    logic [drs_pkg::ROW_W-1:0] row;
    logic [drs_pkg::ROW_W-1:0] col;
    logic ref_pend;
    logic int_req;
    logic [drs_pkg::DIV_W-1:0] div;
    logic [drs_pkg::ROW_W-1:0] rcnt;
    drs_pkg::drs_state_type st;
    logic [2:0] cnt;
    logic [1:0] hold;
    logic wdone;
    logic [drs_pkg::ROW_W-1:0] ma;
    logic ras0;
    logic ras1;
    logic cas;
    logic rdy;
    logic rq_oe;
  } drs_regs_type;
  drs_regs_type cur_ff;
  drs_regs_type nxt_cur;
  logic ale_s;
  logic acx_s;
  logic rq_s;
  logic [2:0] strap_s;
  logic ext_edge;
  logic reset_straps;
  logic [drs_pkg::DIV_W-1:0] div_top;
  logic [2:0] ref_len;
  logic acc_go;
  assign ale_s = cur_ff.s2.ale;
  assign acx_s = cur_ff.s2.access_ctrl_n;
  assign rq_s = cur_ff.rq_sy[1];
  assign strap_s = cur_ff.s2.strap;
  // own low drive echoes back on the pin; not an outside request
  assign ext_edge = cur_ff.req_d & ~rq_s & ~cur_ff.own;
  assign reset_straps = ~|strap_s;
  always_comb
  begin
    // strap decode of divider and refresh length
    case (strap_s)
      3'b001: div_top = drs_pkg::DIV_31;
      3'b010, 3'b100: div_top = drs_pkg::DIV_46;
      3'b011, 3'b101: div_top = drs_pkg::DIV_61;
      3'b110: div_top = drs_pkg::DIV_76;
      3'b111: div_top = drs_pkg::DIV_91;
      default: div_top = drs_pkg::DIV_31;
    endcase
    case (strap_s)
      3'b001, 3'b010, 3'b100: ref_len = drs_pkg::REF_LEN3;
      default: ref_len = drs_pkg::REF_LEN4;
    endcase
  end
  always_comb
  begin
    nxt_cur = cur_ff;
    acc_go = 1'b0;
    // pin synchronisers
    nxt_cur.s1.strap = {wait_strap, rate_select1, rate_select0};
    nxt_cur.s1.cs_n = chip_sel_n;
    nxt_cur.s1.bank = bank_select;
    nxt_cur.s1.col = col_addr;
    nxt_cur.s1.row = row_addr;
    nxt_cur.s1.access_ctrl_n = ~(access_read_n & access_write_n);
    nxt_cur.s1.ale = addr_latch;
    nxt_cur.s2 = cur_ff.s1;
    nxt_cur.rq_sy = {cur_ff.rq_sy[0], refresh_req_n_in};
    nxt_cur.ale_d = ale_s;
    nxt_cur.req_d = rq_s;
    // latch address while strobe is high, request on its fall
    if (ale_s)
    begin
      nxt_cur.row = cur_ff.s2.row;
      nxt_cur.col = cur_ff.s2.col;
      nxt_cur.bank = cur_ff.s2.bank;
    end
    if (cur_ff.ale_d && !ale_s && !cur_ff.s2.cs_n)
      nxt_cur.acc_pend = 1'b1;
    // refresh rate divider
    if (reset_straps)
      nxt_cur.div = '0;
    else if (cur_ff.div >= div_top - drs_pkg::REQ_LEAD)
    begin
      nxt_cur.div = '0;
      nxt_cur.int_req = 1'b1;
    end
    else
      nxt_cur.div = cur_ff.div + 1'b1;
    if (ext_edge)
      nxt_cur.ref_pend = 1'b1;
    if (cur_ff.int_req)
      nxt_cur.ref_pend = 1'b1;
    nxt_cur.rq_oe = cur_ff.int_req | cur_ff.rq_oe;
    nxt_cur.own = cur_ff.rq_oe | (cur_ff.own & ~rq_s);
    nxt_cur.cnt = cur_ff.cnt + 1'b1;
    case (cur_ff.st)
      drs_pkg::DRS_IDLE:
      begin
        nxt_cur.ma = cur_ff.row;
        nxt_cur.cnt = '0;
        // refresh wins arbitration; access waits
        if (cur_ff.ref_pend)
        begin
          nxt_cur.st = drs_pkg::DRS_REF;
          nxt_cur.ma = cur_ff.rcnt;
          nxt_cur.rdy = 1'b0;
        end
        else if (cur_ff.acc_pend || acx_s)
        begin
          acc_go = 1'b1;
          nxt_cur.acc_pend = 1'b0;
          nxt_cur.st = drs_pkg::DRS_ROW;
          nxt_cur.hold = drs_pkg::HOLD_CYC;
          nxt_cur.ras0 = cur_ff.bank;
          nxt_cur.ras1 = ~cur_ff.bank;
          nxt_cur.rdy = 1'b0;
          nxt_cur.wdone = ~strap_s[2];
        end
      end
      drs_pkg::DRS_ROW:
      begin
        if (cur_ff.hold != 2'h0)
          nxt_cur.hold = cur_ff.hold - 1'b1;
        else if (acx_s)
        begin
          nxt_cur.ma = cur_ff.col;
          nxt_cur.st = drs_pkg::DRS_COL;
        end
      end
      drs_pkg::DRS_COL:
      begin
        nxt_cur.cas = 1'b0;
        nxt_cur.st = drs_pkg::DRS_WAIT;
      end
      drs_pkg::DRS_WAIT:
      begin
        if (cur_ff.wdone)
          nxt_cur.rdy = 1'b1;
        else
          nxt_cur.wdone = 1'b1;
        if (!acx_s)
          nxt_cur.st = drs_pkg::DRS_DONE;
      end
      drs_pkg::DRS_DONE:
      begin
        nxt_cur.ras0 = 1'b1;
        nxt_cur.ras1 = 1'b1;
        nxt_cur.cas = 1'b1;
        nxt_cur.rdy = 1'b1;
        nxt_cur.st = drs_pkg::DRS_IDLE;
      end
      drs_pkg::DRS_REF:
      begin
        if (cur_ff.cnt == 3'h0)
        begin
          nxt_cur.ras0 = 1'b0;
          nxt_cur.ras1 = 1'b0;
          nxt_cur.rq_oe = 1'b0;
          nxt_cur.int_req = 1'b0;
          nxt_cur.ref_pend = ext_edge;
          nxt_cur.div = '0;
        end
        if (cur_ff.cnt == ref_len - 3'h2)
        begin
          nxt_cur.ras0 = 1'b1;
          nxt_cur.ras1 = 1'b1;
          nxt_cur.rcnt = cur_ff.rcnt - 1'b1;
        end
        if (cur_ff.cnt == ref_len - 3'h1)
        begin
          nxt_cur.st = drs_pkg::DRS_IDLE;
          nxt_cur.rdy = ~(cur_ff.acc_pend | acx_s);
        end
      end
      default: nxt_cur.st = drs_pkg::DRS_IDLE;
    endcase
    if (acc_go)
      nxt_cur.cnt = '0;
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_ff <= '0;
      cur_ff.rq_sy <= 2'h3;
      cur_ff.req_d <= 1'b1;
      cur_ff.rcnt <= drs_pkg::ROW_RST;
      cur_ff.st <= drs_pkg::DRS_IDLE;
      cur_ff.ras0 <= 1'b1;
      cur_ff.ras1 <= 1'b1;
      cur_ff.cas <= 1'b1;
      cur_ff.rdy <= 1'b1;
    end
    else
      cur_ff <= nxt_cur;
  end
  assign ready = cur_ff.rdy;
  assign refresh_req_n_out = 1'b0;
  assign refresh_req_n_oe = cur_ff.rq_oe;
  assign mem_addr_out = cur_ff.ma;
  assign row_strobe0_n = cur_ff.ras0;
  assign row_strobe1_n = cur_ff.ras1;
  assign col_strobe_n = cur_ff.cas;
endmodule // drs_sequencer
`default_nettype wire
